// ==== hw/ssp_port.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ssp_params.svh"
// =====================================================================
module ssp_port #(
  parameter bit FIRST_SERIAL_PORT = 1'b1  // Only the first port may run audio framing.
) (
  input  wire logic              clock,         // Bus clock, 20 MHz.
  input  wire logic              reset,         // Asynchronous reset, active high.
  input  wire ssp_pkg::ssp_cfg_s cfg,           // Static configuration.
  input  wire logic [`SSP_W-1:0] tx_data,       // Word to send, low aligned.
  input  wire logic              tx_valid,      // Word to send is offered.
  output var  logic              tx_ready,      // Holding register is free.
  output var  logic [`SSP_W-1:0] rx_data,       // Received word, low aligned.
  output var  logic              rx_valid,      // Received word is offered.
  input  wire logic              rx_ready,      // Receiver takes the word.
  output var  logic              overrun,       // Sticky: a received word was dropped.
  input  wire logic              overrun_clear, // Clears the overrun flag.
  input  wire ssp_pkg::ssp_pin_s pin_in,        // Pin levels; sel is the target_select_line or word select.
  output var  ssp_pkg::ssp_pin_s pin_out,       // Pin drive values.
  output var  ssp_pkg::ssp_pin_s pin_oe,        // Pin output enables, high drives.
  output var  logic              mclk_out       // Audio master clock.
);
  import ssp_pkg::*;

  // =====================================================================
  // Input synchronisers
  ssp_pin_s meta_r, sync_r;
  logic     sck_d_r, sel_d_r, ws_prev_r;

  // Two flops per pin, plus delayed copies of sck and sel for edge detection; meta_r is not read by logic.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      meta_r  <= '0;
      sync_r  <= '0;
      sck_d_r <= 1'b0;
      sel_d_r <= 1'b1;
    end
    else
    begin
      meta_r  <= pin_in;
      sync_r  <= meta_r;
      sck_d_r <= sync_r.sck;
      sel_d_r <= sync_r.sel;
    end
  end

  // =====================================================================
  // Configuration decode
  logic [3:0]          spi_len;
  logic [`SSP_KW-1:0]  spi_bits, aud_dl, dl, slot, start;
  logic [7:0]          adiv;
  logic [`SSP_CW-1:0]  half_len;
  logic                audio, ch32, tx_on, rx_on, master, en, cpol_eff;
  assign audio    = cfg.audio_en & FIRST_SERIAL_PORT;
  assign master   = cfg.master;
  assign en       = cfg.enable;
  assign cpol_eff = cfg.cpol & ~audio;
  assign spi_len  = (cfg.spi_len_m1 < `SSP_SPI_MIN_M1) ? `SSP_SPI_MIN_M1 : cfg.spi_len_m1;
  assign spi_bits = {2'h0, spi_len} + 6'h01;
  assign ch32     = cfg.audio_ch32 | (cfg.alen != SSP_ALEN_16);
  assign aud_dl   = (cfg.alen == SSP_ALEN_16) ? `SSP_SLOT16 : (cfg.alen == SSP_ALEN_24) ? `SSP_BITS24 : `SSP_SLOT32;
  assign dl       = audio ? aud_dl : spi_bits;
  assign slot     = audio ? (ch32 ? `SSP_SLOT32 : `SSP_SLOT16) : spi_bits;
  // Philips and PCM data start one bit after the word select edge; LSB mode pads at the front.
  assign start    = !audio ? '0 : (cfg.std == SSP_STD_LSB) ? slot - dl :
                    (cfg.std == SSP_STD_MSB) ? '0 : `SSP_PHIL_DELAY;
  assign adiv     = (cfg.audio_div == 8'h00) ? 8'h01 : cfg.audio_div;
  // Audio bit clock is a quarter of the master clock: 64 bit clocks per stereo frame with 32-bit slots, 32 with 16-bit slots.
  assign half_len = audio ? {adiv, 2'h0} : (`SSP_SPI_HALF0 << cfg.spi_div);
  // Audio is always half duplex; half_tx picks the direction.
  assign tx_on    = audio ? cfg.half_tx : (~cfg.half_duplex | cfg.half_tx);
  assign rx_on    = audio ? ~cfg.half_tx : (~cfg.half_duplex | ~cfg.half_tx);

  // =====================================================================
  // Bit clock events
  ssp_st_e             st_r, st_nxt;
  ssp_pin_s            pin_out_r, pin_oe_r, out_nxt, oe_nxt;
  logic [`SSP_CW-1:0]  cnt_r, gap_r, mgap_r;
  logic [`SSP_SYNC_LAT-1:0] lead_dly_r;
  logic [7:0]          mc_cnt_r;
  logic                m_tick, m_lead, m_trail, s_edge, s_act, s_lead, s_trail, samp, shift, act;
  logic                restart, rx_bit, m_start, m_stop, s_begin, begin_ev, go_ok, rx_room, mc_tog, mclk_r;
  assign m_tick  = (st_r == SSP_RUN) & master & (cnt_r == half_len - 10'h001);
  assign m_lead  = m_tick & (pin_out_r.sck == cpol_eff);
  assign m_trail = m_tick & (pin_out_r.sck != cpol_eff);
  assign s_edge  = sync_r.sck ^ sck_d_r;
  assign s_act   = en & (audio | ~sync_r.sel);  // target_select_line is active low
  assign s_lead  = ~master & s_act & s_edge & (sync_r.sck != cpol_eff);
  assign s_trail = ~master & s_act & s_edge & (sync_r.sck == cpol_eff);
  // Master samples after the synchroniser delay so the pin value matches the leading edge.
  assign samp    = master ? lead_dly_r[`SSP_SYNC_LAT-1] : s_lead;
  assign shift   = master ? m_trail : s_trail;
  assign act     = master ? (st_r == SSP_RUN) : s_act;
  assign rx_bit  = (audio | (~master ^ cfg.half_duplex)) ? sync_r.mosi : sync_r.miso;
  // Target word alignment restarts on the word select edge seen at a sample.
  assign restart = audio & s_lead & ((cfg.std == SSP_STD_PCM) ? (sync_r.sel & ~ws_prev_r)
                                                              : (sync_r.sel ^ ws_prev_r));

  // =====================================================================
  // Bit position and data selection
  logic [`SSP_KW-1:0] k_r, k_samp, k_nxt, k_a, idx_s, bi;
  logic [`SSP_W-1:0]  tx_sh_r, rx_sh_r, tx_hold_r, ld_word, w_a, rx_word, rx_mask;
  logic [`SSP_W-1:0]  spare_r;
  logic               spare_v_r;
  logic               k_last, in_s, in_a, push, load, ch_r, ch_a, ws_a, tx_full_r, tx_take;
  logic               rx_full, pop, push_ok;
  assign k_samp  = restart ? '0 : k_r;
  assign idx_s   = k_samp - start;
  assign in_s    = (k_samp >= start) & (idx_s < dl);
  assign push    = samp & rx_on & in_s & (idx_s == dl - 6'h01);
  assign rx_mask = {`SSP_W{1'b1}} >> (`SSP_SLOT32 - dl);
  assign rx_word = {rx_sh_r[`SSP_W-2:0], rx_bit} & rx_mask;
  assign k_last  = (k_r == slot - 6'h01);
  assign k_nxt   = k_last ? '0 : k_r + 6'h01;
  assign rx_full = rx_valid & spare_v_r;
  assign pop     = rx_valid & rx_ready;
  // Room is checked including a word landing this very cycle, so an SPI master never overruns; an audio master does not check it.
  assign rx_room = ~rx_valid | (~spare_v_r & ~push);
  assign go_ok   = (~tx_on | tx_full_r) & (~rx_on | rx_room);
  assign m_start = (st_r == SSP_IDLE) & en & master & (audio | go_ok);
  assign m_stop  = m_trail & k_last & ~audio & ~go_ok;
  assign s_begin = ~master & ~audio & en & ~sync_r.sel & sel_d_r;
  assign begin_ev = m_start | s_begin;
  assign load    = s_begin | (m_start & (start == '0)) | (shift & (k_nxt == start) & ~m_stop);
  assign tx_take = load & tx_on & tx_full_r;
  assign ld_word = (tx_on & tx_full_r) ? tx_hold_r : '0;
  assign w_a     = load ? ld_word : tx_sh_r;
  assign k_a     = begin_ev ? '0 : k_nxt;
  assign bi      = dl - 6'h01 - (k_a - start);
  assign in_a    = (k_a >= start) & ((k_a - start) < dl);
  assign ch_a    = begin_ev ? 1'b0 : (k_last ? ~ch_r : ch_r);
  // Philips: low is left. MSB and LSB: high is left. PCM: one-bit pulse before the frame.
  assign ws_a    = (cfg.std == SSP_STD_PHILIPS) ? ch_a :
                   (cfg.std == SSP_STD_PCM) ? ((k_a == '0) & ~ch_a) : ~ch_a;
  assign mc_tog  = audio & master & cfg.mclk_en & (st_r == SSP_RUN) & (mc_cnt_r == adiv - 8'h01);

  // =====================================================================
  // Master sequencer
  always_comb
  begin
    unique case (st_r)
      SSP_IDLE: st_nxt = m_start ? SSP_RUN : SSP_IDLE;
      SSP_RUN:  st_nxt = (m_stop | ~en | ~master) ? SSP_IDLE : SSP_RUN;
    endcase
  end

  // Pin drive values and enables, registered so every pin comes from a flop.
  assign out_nxt.sck  = (st_nxt == SSP_RUN) ? (pin_out_r.sck ^ m_tick) : cpol_eff;
  assign out_nxt.mosi = ~en ? 1'b0 : (shift | begin_ev) ? (in_a & w_a[bi[4:0]]) : pin_out_r.mosi;
  assign out_nxt.miso = out_nxt.mosi;
  assign out_nxt.sel  = audio ? ((master & (shift | m_start)) ? ws_a : pin_out_r.sel) : (st_nxt != SSP_RUN);
  assign oe_nxt.sck   = en & master;
  assign oe_nxt.mosi  = en & tx_on & (master | audio);
  assign oe_nxt.miso  = en & tx_on & ~master & ~audio & ~sync_r.sel;
  assign oe_nxt.sel   = en & master;

  // Sequencer state, pins and bit clock divider.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      st_r       <= SSP_IDLE;
      pin_out_r  <= '{sck: 1'b0, mosi: 1'b0, miso: 1'b0, sel: 1'b1};
      pin_oe_r   <= '0;
      cnt_r      <= '0;
      lead_dly_r <= '0;
    end
    else
    begin
      st_r       <= st_nxt;
      pin_out_r  <= out_nxt;
      pin_oe_r   <= oe_nxt;
      cnt_r      <= (begin_ev | m_tick | (st_r != SSP_RUN)) ? '0 : cnt_r + 10'h001;
      lead_dly_r <= {lead_dly_r[`SSP_SYNC_LAT-2:0], m_lead};
    end
  end

  // Bit position, channel and shift registers.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      k_r       <= '0;
      ch_r      <= 1'b0;
      tx_sh_r   <= '0;
      rx_sh_r   <= '0;
      ws_prev_r <= 1'b0;
    end
    else
    begin
      k_r       <= (~act | begin_ev | restart) ? '0 : shift ? k_nxt : k_r;
      ch_r      <= (~act | begin_ev) ? 1'b0 : (shift & k_last) ? ~ch_r : ch_r;
      tx_sh_r   <= load ? ld_word : tx_sh_r;
      rx_sh_r   <= (samp & in_s) ? rx_word : rx_sh_r;
      ws_prev_r <= s_lead ? sync_r.sel : ws_prev_r;
    end
  end

  // Audio master clock: toggles every adiv cycles, four per bit clock half period.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      mc_cnt_r <= '0;
      mclk_r   <= 1'b0;
    end
    else
    begin
      mc_cnt_r <= (begin_ev | (st_r != SSP_RUN) | mc_tog) ? '0 : mc_cnt_r + 8'h01;
      mclk_r   <= (audio & master & cfg.mclk_en & (st_r == SSP_RUN)) ? (mclk_r ^ mc_tog) : 1'b0;
    end
  end
  assign mclk_out = mclk_r;
  assign pin_out  = pin_out_r;
  assign pin_oe   = pin_oe_r;

  // =====================================================================
  // Transmit holding register and two-entry receive buffer
  assign push_ok = push & (~rx_full | pop);

  // Holding register; ready is registered, so one word is taken per free slot.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      tx_full_r <= 1'b0;
      tx_hold_r <= '0;
      tx_ready  <= 1'b0;
    end
    else
    begin
      tx_full_r <= (tx_full_r & ~tx_take) | (tx_valid & tx_ready);
      tx_hold_r <= (tx_valid & tx_ready) ? tx_data : tx_hold_r;
      tx_ready  <= ~((tx_full_r & ~tx_take) | (tx_valid & tx_ready));
    end
  end

  // A target or audio port cannot stall the far side, so a word arriving while both entries are full is dropped unless one is popped in the same cycle.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      rx_valid  <= 1'b0;
      rx_data   <= '0;
      spare_v_r <= 1'b0;
      spare_r   <= '0;
      overrun   <= 1'b0;
    end
    else
    begin
      rx_valid  <= (rx_valid & ~pop) | spare_v_r | push_ok;
      rx_data   <= (pop | ~rx_valid) ? (spare_v_r ? spare_r : rx_word) : rx_data;
      spare_v_r <= (spare_v_r & ~pop) | (push_ok & rx_valid & (~pop | spare_v_r));
      spare_r   <= (push_ok & rx_valid & (~pop | spare_v_r)) ? rx_word : spare_r;
      overrun   <= (push & rx_full & ~pop) | (overrun & ~overrun_clear);
    end
  end

  // =====================================================================
  // Checks
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      gap_r  <= '0;
      mgap_r <= '0;
    end
    else
    begin
      gap_r  <= (begin_ev | m_tick) ? 10'h001 : gap_r + 10'h001;
      mgap_r <= (begin_ev | mc_tog) ? 10'h001 : mgap_r + 10'h001;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  spi_rate_a:    assert property (m_tick && !audio |-> gap_r == (`SSP_SPI_HALF0 << cfg.spi_div) ##1 $changed(pin_out_r.sck)) else $error("SPI bit clock half period wrong.");
  aud_rate_a:    assert property (m_tick && audio |-> gap_r == {adiv, 2'h0}) else $error("Audio bit clock half period wrong.");
  mclk_rate_a:   assert property (mc_tog |-> mgap_r == {2'h0, adiv} ##1 mclk_out != $past(mclk_out)) else $error("Master clock period wrong.");
  frame_len_a:   assert property (push && !audio |-> dl >= `SSP_SPI_MIN && dl <= `SSP_SPI_MAX && k_samp == dl - 6'h01) else $error("SPI frame length out of range.");
  aud_len_a:     assert property (push && audio |-> (dl == `SSP_SLOT16 || dl == `SSP_BITS24 || dl == `SSP_SLOT32) && dl <= slot) else $error("Audio word length wrong.");
  aud_half_a:    assert property (audio && !cfg.half_tx && $past(audio && !cfg.half_tx) |-> !pin_oe_r.mosi && !pin_oe_r.miso) else $error("Audio receive drives data.");
  sel_frame_a:   assert property (!audio && master && st_r == SSP_RUN && $past(st_r == SSP_RUN) |-> !pin_out_r.sel) else $error("Select released inside a frame.");
  no_drop_a:     assert property (master && !audio && push |-> !rx_full || pop) else $error("Master dropped a received word.");
  spi_word_c:    cover property (!audio && master && push ##[1:40] rx_valid);
  aud_frame_c:   cover property (audio && master && shift && k_last && ch_r);
  overrun_c:     cover property ($rose(overrun));
  target_sel_c:  cover property (s_begin ##[1:200] push);
endmodule // ssp_port
`default_nettype wire

// ==== hw/ssp_params.svh ====
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
// =====================================================================
// Widths
`define SSP_W           32
`define SSP_KW          6
`define SSP_CW          10
// =====================================================================
// Frame sizes in bits
`define SSP_SPI_MIN_M1  4'h3
`define SSP_SPI_MIN     6'h04
`define SSP_SPI_MAX     6'h10
`define SSP_SLOT16      6'h10
`define SSP_BITS24      6'h18
`define SSP_SLOT32      6'h20
`define SSP_PHIL_DELAY  6'h01
// =====================================================================
// Clock division: the SPI half period is this value shifted left by the divider.
`define SSP_SPI_HALF0   10'h002
// =====================================================================
// Master sample delay equals the input synchroniser depth.
`define SSP_SYNC_LAT    2
`endif

// ==== hw/ssp_pkg.sv ====
// =====================================================================
// Shared types of the serial port.
package ssp_pkg;
  typedef enum logic [1:0] {SSP_STD_PHILIPS = 2'h0, SSP_STD_MSB = 2'h1,
                            SSP_STD_LSB = 2'h2, SSP_STD_PCM = 2'h3} ssp_std_e;
  typedef enum logic [1:0] {SSP_ALEN_16 = 2'h0, SSP_ALEN_24 = 2'h1, SSP_ALEN_32 = 2'h2} ssp_alen_e;
  typedef enum logic {SSP_IDLE = 1'b0, SSP_RUN = 1'b1} ssp_st_e;
  typedef struct packed {
    logic      enable;
    logic      master;
    logic      half_duplex;
    logic      half_tx;
    logic      cpol;
    logic [2:0] spi_div;
    logic [3:0] spi_len_m1;
    logic      audio_en;
    ssp_std_e  std;
    ssp_alen_e alen;
    logic      audio_ch32;
    logic [7:0] audio_div;
    logic      mclk_en;
  } ssp_cfg_s;
  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic sel;
  } ssp_pin_s;
endpackage

// ==== bench/ssp_spi_target_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// Behavioural peripheral on the far side of the master link.
module ssp_spi_target_model (
  input  wire logic        sck,   // Serial clock from the master.
  input  wire logic        sel_n, // Target select, active low.
  input  wire logic        mosi,  // Data from the master.
  input  wire logic        cpol,  // Idle level of sck.
  input  wire logic [4:0]  len,   // Bits per frame.
  input  wire logic [15:0] resp,  // Word returned in every frame.
  output var  logic        miso   // Data to the master.
);
  logic [15:0] sh = 16'h0000;
  logic [15:0] got = 16'h0000;
  logic [4:0]  cnt = 5'h00;
  logic [15:0] words[$]; // Captured words, read by the bench.
  initial miso = 1'b0;
  // First bit goes out on select, before the first leading edge.
  always @(negedge sel_n)
  begin
    sh = resp << (16 - len);
    miso = sh[15];
    cnt = 5'h00;
    got = 16'h0000;
  end
  // Sample on leading edges; shift on trailing ones, reloading after the last bit
  // because select may stay low across back-to-back frames.
  always @(sck)
    if (sel_n === 1'b0)
    begin
      if (sck !== cpol)
      begin
        got = {got[14:0], mosi};
        cnt = cnt + 5'h01;
        if (cnt == len) words.push_back(got);
      end
      else
      begin
        if (cnt == len)
        begin
          sh = resp << (16 - len);
          cnt = 5'h00;
          got = 16'h0000;
        end
        else sh = sh << 1;
        miso = sh[15];
      end
    end
  // A released line must not keep showing a valid-looking bit.
  always @(posedge sel_n) miso = ~miso;
endmodule // ssp_spi_target_model
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "ssp_params.svh"
// =====================================================================
// Bench for the serial port: master link, stall path and audio clocks.
module tb;
  import ssp_pkg::*;
  logic              clock, reset, tx_valid, tx_ready, rx_valid, rx_ready;
  logic              overrun, overrun_clear, mclk_out, miso_far;
  logic              tog = 1'b0, sck_p = 1'b0, mclk_p = 1'b0, ws_p = 1'b0;
  logic [`SSP_W-1:0] tx_data, rx_data, w3[3];
  logic [15:0]       resp;
  logic [3:0]        lm1;
  logic [7:0]        adiv;
  ssp_cfg_s          cfg;
  ssp_pin_s          pin_in, pin_out, pin_oe;
  int                failures, n_checks, seed;
  int                sck_cnt = 0, sck_half = 0, mclk_cnt = 0, mclk_half = 0, mrise = 0, ws_period = 0;
  ssp_port #(.FIRST_SERIAL_PORT(1'b1)) dut (.clock(clock), .reset(reset), .cfg(cfg), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .overrun(overrun), .overrun_clear(overrun_clear), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .mclk_out(mclk_out));
  ssp_spi_target_model partner (.sck(pin_in.sck), .sel_n(pin_in.sel), .mosi(pin_in.mosi), .cpol(cfg.cpol),
    .len({1'b0, cfg.spi_len_m1} + 5'h01), .resp(resp), .miso(miso_far));
  // Undriven sck and mosi toggle so a stale level cannot pass; undriven miso follows the target model; select has a pull-up.
  assign pin_in = '{sck: pin_oe.sck ? pin_out.sck : tog, mosi: pin_oe.mosi ? pin_out.mosi : tog,
                    miso: pin_oe.miso ? pin_out.miso : miso_far, sel: pin_oe.sel ? pin_out.sel : 1'b1};
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Measure half periods of sck and mclk, and mclk rises per word-select period.
  always @(posedge clock)
  begin
    tog <= ~tog;
    sck_p <= pin_out.sck;
    mclk_p <= mclk_out;
    ws_p <= pin_out.sel;
    sck_cnt <= (pin_out.sck !== sck_p) ? 1 : sck_cnt + 1;
    if (pin_out.sck !== sck_p) sck_half <= sck_cnt;
    mclk_cnt <= (mclk_out !== mclk_p) ? 1 : mclk_cnt + 1;
    if (mclk_out !== mclk_p) mclk_half <= mclk_cnt;
    if (pin_out.sel && !ws_p) ws_period <= mrise;
    mrise <= ((pin_out.sel && !ws_p) ? 0 : mrise) + ((mclk_out && !mclk_p) ? 1 : 0);
  end
  function automatic logic [31:0] mask(input logic [31:0] w, input logic [3:0] m1);
    return w & ((32'h2 << m1) - 32'h1);
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude;
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Configuration changes only while the port is disabled.
  task automatic setcfg(input logic aud, input logic [2:0] div, input logic [3:0] m1, input logic [1:0] std,
                        input logic [7:0] ad);
    ssp_cfg_s c;
    c = '{enable: 1'b0, master: 1'b1, half_duplex: aud, half_tx: 1'b1, cpol: !aud && div[0], spi_div: div,
          spi_len_m1: m1, audio_en: aud, std: ssp_std_e'(std),
          alen: ssp_alen_e'((std == 2'h3) ? 2'h0 : std), audio_ch32: 1'b1, audio_div: ad, mclk_en: aud};
    @(posedge clock) cfg.enable <= 1'b0;
    @(posedge clock) cfg <= c;
    @(posedge clock) cfg.enable <= 1'b1;
  endtask
  task automatic send(input logic [31:0] w);
    int n;
    n = 0;
    @(posedge clock);
    tx_data <= w;
    tx_valid <= 1'b1;
    do begin @(negedge clock); n++; end while (tx_ready !== 1'b1 && n < 20000);
    if (n >= 20000) failures++;
    @(posedge clock) tx_valid <= 1'b0;
  endtask
  task automatic pop(input string what, input logic [31:0] exp);
    int n;
    n = 0;
    do begin @(negedge clock); n++; end while (rx_valid !== 1'b1 && n < 40000);
    if (n >= 40000) failures++;
    chk(what, exp, rx_data);
    @(posedge clock) rx_ready <= 1'b1;
    @(posedge clock) rx_ready <= 1'b0;
  endtask
  // Main sequence.
  initial
  begin
    seed = 97204;
    failures = 0;
    n_checks = 0;
    reset = 1'b1;
    cfg = '0;
    tx_data = '0;
    tx_valid = 1'b0;
    rx_ready = 1'b0;
    overrun_clear = 1'b0;
    resp = 16'h0000;
    repeat (3) @(posedge clock);
    chk("tx_ready in reset", 32'h0, 32'(tx_ready));
    chk("pin_oe in reset", 32'h0, 32'(pin_oe));
    reset <= 1'b0;
    // Every divider setting, frame lengths at both ends and random between.
    for (int d = 0; d < 8; d++)
    begin
      lm1 = (d == 0 || d > 3) ? 4'h3 : (d == 1) ? 4'hF : 4'h3 + 4'(unsigned'($random(seed)) % 13);
      setcfg(1'b0, 3'(d), lm1, 2'h0, 8'h01);
      resp = 16'($random(seed));
      w3[0] = $random(seed);
      send(w3[0]);
      pop("spi rx word", mask({16'h0000, resp}, lm1));
      chk("spi tx word", mask(w3[0], lm1), 32'(partner.words.pop_front()));
      chk("sck half period", 32'h2 << d, 32'(sck_half));
    end
    // Receiver stalls: two entries fill and the third frame must wait for room.
    setcfg(1'b0, 3'h0, 4'h7, 2'h0, 8'h01);
    for (int i = 0; i < 3; i++) w3[i] = $random(seed);
    for (int i = 0; i < 3; i++) send(w3[i]);
    repeat (200) @(posedge clock);
    chk("frames while stalled", 32'h2, 32'(partner.words.size()));
    chk("overrun while stalled", 32'h0, 32'(overrun));
    @(posedge clock) overrun_clear <= 1'b1;
    @(posedge clock) overrun_clear <= 1'b0;
    for (int i = 0; i < 3; i++) pop("stalled rx word", mask({16'h0000, resp}, 4'h7));
    for (int i = 0; i < 3; i++) chk("stalled tx word", mask(w3[i], 4'h7), 32'(partner.words.pop_front()));
    // Audio master in each standard; the transmitter is kept fed.
    for (int s = 0; s < 4; s++)
    begin
      adiv = 8'(1 + unsigned'($random(seed)) % 3);
      setcfg(1'b1, 3'h0, 4'h3, 2'(s), adiv);
      @(posedge clock);
      tx_data <= $random(seed);
      tx_valid <= 1'b1;
      repeat (1600 * adiv) @(posedge clock);
      @(negedge clock);
      chk("mclk half period", 32'(adiv), 32'(mclk_half));
      chk("audio sck half period", 32'(adiv) * 4, 32'(sck_half));
      if (s < 3) chk("mclk per sample", 32'd256, 32'(ws_period));
      @(posedge clock) tx_valid <= 1'b0;
    end
    conclude();
  end
  // Watchdog for a hung handshake.
  initial
  begin
    #4500000;
    failures++;
    conclude();
  end
endmodule // tb
`default_nettype wire
